// File: rtl/pmst_params.svh
// Constants of the power-management standby timer block: register indices,
// field positions, time slots and trap address tags.
// Assumes a 20 MHz host clock and word-aligned AXI4-Lite register access.
`ifndef PMST_PARAMS_SVH
`define PMST_PARAMS_SVH

`define PMST_CLK_MHZ 20
`define PMST_AW 9
`define PMST_IDX_W 7

// Register indices; the byte address is four times the index
`define PMST_IDX_SYS_CNT 7'h63
`define PMST_IDX_WAKE 7'h6A
`define PMST_IDX_MON_LO 7'h6B
`define PMST_IDX_MON_HI 7'h6C
`define PMST_IDX_PORT_LO 7'h6D
`define PMST_IDX_PORT_HI 7'h6E
`define PMST_IDX_EVSEL 7'h6F
`define PMST_IDX_CTL 7'h70
`define PMST_IDX_STAT 7'h71

// Wake request and enable bits
`define PMST_WK_SYS_REQ 0
`define PMST_WK_SYS_EN 1
`define PMST_WK_THR_EN 2
`define PMST_WK_THR_REQ 3
// Idle event select bits
`define PMST_EV_BUS_RET 7
`define PMST_EV_SPARE 6
`define PMST_EV_VMEM 5
`define PMST_EV_VBIOS 4
`define PMST_EV_VIO 3
`define PMST_EV_SECDRV 2
`define PMST_EV_SYS_SLOT 0
// Control bits
`define PMST_CTL_MON_EN 0
`define PMST_CTL_SYS_EN 1
`define PMST_CTL_SB_SMI_EN 2
`define PMST_CTL_MON_SLOT 3
// Status bits
`define PMST_ST_SB_REQ 0
`define PMST_ST_STANDBY 1
`define PMST_ST_MON_EXP 2

`define PMST_RESP_OKAY 2'h0
`define PMST_RESP_SLVERR 2'h2

// Slot lengths in microseconds, and in clock cycles
`define PMST_MON_SLOT0_US 6600000
`define PMST_MON_SLOT1_US 840000
`define PMST_MON_SLOT2_US 13300
`define PMST_MON_SLOT3_US 1600
`define PMST_SYS_SLOT0_US 9000000
`define PMST_SYS_SLOT1_US 1100000
`define PMST_SYS_SLOT2_US 70000
`define PMST_SYS_SLOT3_US 8850
`define PMST_MON_SLOT0_CYC (`PMST_MON_SLOT0_US * `PMST_CLK_MHZ)
`define PMST_MON_SLOT1_CYC (`PMST_MON_SLOT1_US * `PMST_CLK_MHZ)
`define PMST_MON_SLOT2_CYC (`PMST_MON_SLOT2_US * `PMST_CLK_MHZ)
`define PMST_MON_SLOT3_CYC (`PMST_MON_SLOT3_US * `PMST_CLK_MHZ)
`define PMST_SYS_SLOT0_CYC (`PMST_SYS_SLOT0_US * `PMST_CLK_MHZ)
`define PMST_SYS_SLOT1_CYC (`PMST_SYS_SLOT1_US * `PMST_CLK_MHZ)
`define PMST_SYS_SLOT2_CYC (`PMST_SYS_SLOT2_US * `PMST_CLK_MHZ)
`define PMST_SYS_SLOT3_CYC (`PMST_SYS_SLOT3_US * `PMST_CLK_MHZ)

// Trap address tags
`define PMST_VMEM_TAG 15'h0005
`define PMST_VBIOS_TAG 17'h00018
`define PMST_VIO_B 12'h03B
`define PMST_VIO_C 12'h03C
`define PMST_VIO_D 12'h03D
`define PMST_SEC_A 12'h017
`define PMST_SEC_B 12'h032
`define PMST_SEC_C 16'h03F7

`endif

// File: rtl/pmst_pkg.sv
// Types of the power-management standby timer block.
// Assumes pmst_params.svh supplies the numeric constants.
package pmst_pkg;

  typedef logic [15:0] pmst_cnt_t;

  typedef struct packed {
    logic [31:0] presc;
    pmst_cnt_t count;
    logic en_d;
    logic expire;
  } pmst_tmr_st_t;

  typedef struct packed {
    logic aw_hold;
    logic w_hold;
    logic [6:0] aw_idx;
    logic [7:0] w_data;
    logic w_strb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [7:0] sys_prog;
    logic [3:0] wake;
    pmst_cnt_t mon_prog;
    pmst_cnt_t io_port;
    logic [7:0] evsel;
    logic [4:0] ctl;
    logic [2:0] stat;
    logic smi;
    logic port_hit;
    logic [17:0] sync1;
    logic [17:0] sync2;
    logic [17:0] prev;
  } pmst_top_st_t;

endpackage : pmst_pkg

// File: rtl/pmst_tmr_if.sv
// Carrier between the register block and one count-down timer.
// Assumes both ends run on the same host clock.
`timescale 1ns/1ps
interface pmst_tmr_if;
  logic en;
  logic reload;
  logic [15:0] load_val;
  logic [31:0] slot_len;
  logic [15:0] count;
  logic expire;
  modport ctl (output en, output reload, output load_val, output slot_len,
               input count, input expire);
  modport tmr (input en, input reload, input load_val, input slot_len,
               output count, output expire);
endinterface : pmst_tmr_if

// File: rtl/pmst_timer.sv
// Idle count-down timer with a slot prescaler.
// Assumes slot_len is at least 1 and the controls come from the aclk domain.
`timescale 1ns/1ps
module pmst_timer (
  input wire logic aclk,
  input wire logic aresetn,
  pmst_tmr_if.tmr t
);
  import pmst_pkg::*;

  pmst_tmr_st_t r;
  pmst_tmr_st_t n;

  assign t.count = r.count;
  assign t.expire = r.expire;

  always_comb
  begin
    n = r;
    n.expire = 1'b0;
    n.en_d = t.en;
    if (!t.en)
    begin
      n.presc = '0;
    end
    else if ((t.en && !r.en_d) || t.reload)
    begin
      n.count = t.load_val;
      n.presc = '0;
    end
    else if (r.count != 16'h0000)
    begin
      if (r.presc >= t.slot_len - 32'h00000001)
      begin
        n.presc = '0;
        n.count = r.count - 16'h0001;
        n.expire = (r.count == 16'h0001);
      end
      else
      begin
        n.presc = r.presc + 32'h00000001;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else
      r <= n;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reload_load_a: assert property (t.en && r.en_d && t.reload |=> r.count == $past(t.load_val))
    else $error("timer did not reload on event");
  slot_step_a: assert property (t.en && r.en_d && !t.reload && $past(t.en) && r.count != 16'h0
      && r.presc >= t.slot_len - 32'h1 |=> r.count == $past(r.count) - 16'h1)
    else $error("timer did not step once per slot");

endmodule : pmst_timer

// File: rtl/pmst_top.sv
// Power-management standby timers: monitor and system idle timers, address
// traps, wake request bits and the system management interrupt.
// Assumes an AXI4-Lite master on aclk; event pins are asynchronous, bus cycle
// inputs and throttle_state come from logic on aclk.
`timescale 1ns/1ps
`include "pmst_params.svh"
module pmst_top #(
  parameter logic [31:0] MON_SLOT0_CYC = `PMST_MON_SLOT0_CYC,
  parameter logic [31:0] MON_SLOT1_CYC = `PMST_MON_SLOT1_CYC,
  parameter logic [31:0] MON_SLOT2_CYC = `PMST_MON_SLOT2_CYC,
  parameter logic [31:0] MON_SLOT3_CYC = `PMST_MON_SLOT3_CYC,
  parameter logic [31:0] SYS_SLOT0_CYC = `PMST_SYS_SLOT0_CYC,
  parameter logic [31:0] SYS_SLOT1_CYC = `PMST_SYS_SLOT1_CYC,
  parameter logic [31:0] SYS_SLOT2_CYC = `PMST_SYS_SLOT2_CYC,
  parameter logic [31:0] SYS_SLOT3_CYC = `PMST_SYS_SLOT3_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [8:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [8:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic nmi,
  input wire logic init,
  input wire logic hold,
  input wire logic [15:1] irq,
  input wire logic throttle_state,
  input wire logic cyc_valid,
  input wire logic cyc_io,
  input wire logic [31:0] cyc_addr,
  output logic smi,
  output logic system_standby,
  output logic monitor_idle_expired,
  output logic io_port_hit,
  output logic bus_return_en,
  output logic spare_board_output
);
  import pmst_pkg::*;

  pmst_top_st_t r;
  pmst_top_st_t n;
  pmst_tmr_if mon_if ();
  pmst_tmr_if sys_if ();

  logic [17:0] ev_edge;
  logic ev_wake;
  logic ev_mon;
  logic hit_vmem;
  logic hit_vbios;
  logic hit_vio;
  logic hit_sec;
  logic [3:0] wk_clr;
  logic [2:0] st_clr;
  logic wr_go;
  logic rd_map;
  logic [7:0] rd_val;

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  // Edges, not levels, count as events so a stuck line cannot pin the timer
  assign ev_edge = r.sync2 & ~r.prev;
  assign ev_wake = |ev_edge;
  assign ev_mon = ev_edge[17] | (|ev_edge[15:0]);

  assign hit_vmem = cyc_valid && !cyc_io && r.evsel[`PMST_EV_VMEM]
    && cyc_addr[31:17] == `PMST_VMEM_TAG;
  assign hit_vbios = cyc_valid && !cyc_io && r.evsel[`PMST_EV_VBIOS]
    && cyc_addr[31:15] == `PMST_VBIOS_TAG;
  assign hit_vio = cyc_valid && cyc_io && r.evsel[`PMST_EV_VIO]
    && (cyc_addr[15:4] == `PMST_VIO_B || cyc_addr[15:4] == `PMST_VIO_C
    || cyc_addr[15:4] == `PMST_VIO_D);
  assign hit_sec = cyc_valid && cyc_io && r.evsel[`PMST_EV_SECDRV]
    && (cyc_addr[15:4] == `PMST_SEC_A || cyc_addr[15:4] == `PMST_SEC_B
    || cyc_addr[15:0] == `PMST_SEC_C);

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  assign mon_if.en = r.ctl[`PMST_CTL_MON_EN];
  assign mon_if.reload = ev_mon;
  assign mon_if.load_val = r.mon_prog;
  assign sys_if.en = r.ctl[`PMST_CTL_SYS_EN];
  assign sys_if.reload = hit_vmem || hit_vbios || hit_vio || hit_sec;
  assign sys_if.load_val = {8'h00, r.sys_prog};

  always_comb
  begin
    unique case (r.ctl[`PMST_CTL_MON_SLOT +: 2])
      2'h0: mon_if.slot_len = MON_SLOT0_CYC;
      2'h1: mon_if.slot_len = MON_SLOT1_CYC;
      2'h2: mon_if.slot_len = MON_SLOT2_CYC;
      2'h3: mon_if.slot_len = MON_SLOT3_CYC;
    endcase
  end

  always_comb
  begin
    unique case (r.evsel[`PMST_EV_SYS_SLOT +: 2])
      2'h0: sys_if.slot_len = SYS_SLOT0_CYC;
      2'h1: sys_if.slot_len = SYS_SLOT1_CYC;
      2'h2: sys_if.slot_len = SYS_SLOT2_CYC;
      2'h3: sys_if.slot_len = SYS_SLOT3_CYC;
    endcase
  end

  pmst_timer u_mon (
    .aclk(aclk),
    .aresetn(aresetn),
    .t(mon_if)
  );

  pmst_timer u_sys (
    .aclk(aclk),
    .aresetn(aresetn),
    .t(sys_if)
  );

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_map = 1'b1;
    rd_val = 8'h00;
    unique case (araddr[8:2])
      `PMST_IDX_SYS_CNT: rd_val = r.sys_prog;
      `PMST_IDX_WAKE: rd_val = {4'h0, r.wake};
      `PMST_IDX_MON_LO: rd_val = mon_if.count[7:0];
      `PMST_IDX_MON_HI: rd_val = mon_if.count[15:8];
      `PMST_IDX_PORT_LO: rd_val = r.io_port[7:0];
      `PMST_IDX_PORT_HI: rd_val = r.io_port[15:8];
      `PMST_IDX_EVSEL: rd_val = r.evsel;
      `PMST_IDX_CTL: rd_val = {3'h0, r.ctl};
      `PMST_IDX_STAT: rd_val = {5'h00, r.stat};
      default: rd_map = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n = r;
    wk_clr = 4'h0;
    st_clr = 3'h0;
    wr_go = r.aw_hold && r.w_hold && !r.bvalid;
    n.sync1 = {nmi, init, hold, irq};
    n.sync2 = r.sync1;
    n.prev = r.sync2;
    n.port_hit = cyc_valid && cyc_io && cyc_addr[15:0] == r.io_port;

    if (awvalid && r.awready)
    begin
      n.aw_hold = 1'b1;
      n.aw_idx = awaddr[8:2];
    end
    if (wvalid && r.wready)
    begin
      n.w_hold = 1'b1;
      n.w_data = wdata[7:0];
      n.w_strb0 = wstrb[0];
    end
    if (r.bvalid && bready)
      n.bvalid = 1'b0;

    if (wr_go)
    begin
      n.aw_hold = 1'b0;
      n.w_hold = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `PMST_RESP_OKAY;
      unique case (r.aw_idx)
        `PMST_IDX_SYS_CNT: if (r.w_strb0) n.sys_prog = r.w_data;
        `PMST_IDX_WAKE:
        begin
          if (r.w_strb0)
          begin
            n.wake[`PMST_WK_SYS_EN] = r.w_data[`PMST_WK_SYS_EN];
            n.wake[`PMST_WK_THR_EN] = r.w_data[`PMST_WK_THR_EN];
            wk_clr = r.w_data[3:0];
          end
        end
        `PMST_IDX_MON_LO: if (r.w_strb0) n.mon_prog[7:0] = r.w_data;
        `PMST_IDX_MON_HI: if (r.w_strb0) n.mon_prog[15:8] = r.w_data;
        `PMST_IDX_PORT_LO: if (r.w_strb0) n.io_port[7:0] = r.w_data;
        `PMST_IDX_PORT_HI: if (r.w_strb0) n.io_port[15:8] = r.w_data;
        `PMST_IDX_EVSEL: if (r.w_strb0) n.evsel = r.w_data;
        `PMST_IDX_CTL: if (r.w_strb0) n.ctl = r.w_data[4:0];
        `PMST_IDX_STAT: if (r.w_strb0) st_clr = r.w_data[2:0];
        default: n.bresp = `PMST_RESP_SLVERR;
      endcase
    end
    n.awready = !n.aw_hold && !n.bvalid;
    n.wready = !n.w_hold && !n.bvalid;

    if (arvalid && r.arready)
    begin
      n.rvalid = 1'b1;
      n.rdata = rd_val;
      n.rresp = rd_map ? `PMST_RESP_OKAY : `PMST_RESP_SLVERR;
    end
    if (r.rvalid && rready)
      n.rvalid = 1'b0;
    n.arready = !n.rvalid;

    // software clear; a set in the same cycle wins over the clear
    n.wake[`PMST_WK_THR_REQ] = r.wake[`PMST_WK_THR_REQ] && !wk_clr[`PMST_WK_THR_REQ];
    n.wake[`PMST_WK_SYS_REQ] = r.wake[`PMST_WK_SYS_REQ] && !wk_clr[`PMST_WK_SYS_REQ];
    n.stat = r.stat & ~st_clr;
    if (ev_wake && throttle_state)
      n.wake[`PMST_WK_THR_REQ] = 1'b1;
    if (ev_wake && r.stat[`PMST_ST_STANDBY])
      n.wake[`PMST_WK_SYS_REQ] = 1'b1;
    if (mon_if.expire)
      n.stat[`PMST_ST_MON_EXP] = 1'b1;
    if (sys_if.expire && r.ctl[`PMST_CTL_SB_SMI_EN])
    begin
      n.stat[`PMST_ST_SB_REQ] = 1'b1;
      n.stat[`PMST_ST_STANDBY] = 1'b1;
    end

    n.smi = (n.wake[`PMST_WK_THR_REQ] && n.wake[`PMST_WK_THR_EN])
      || (n.wake[`PMST_WK_SYS_REQ] && n.wake[`PMST_WK_SYS_EN])
      || (n.stat[`PMST_ST_SB_REQ] && n.ctl[`PMST_CTL_SB_SMI_EN]);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else
      r <= n;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign awready = r.awready;
  assign wready = r.wready;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign arready = r.arready;
  assign rvalid = r.rvalid;
  assign rresp = r.rresp;
  assign rdata = {24'h000000, r.rdata};
  assign smi = r.smi;
  assign system_standby = r.stat[`PMST_ST_STANDBY];
  assign monitor_idle_expired = r.stat[`PMST_ST_MON_EXP];
  assign io_port_hit = r.port_hit;
  assign bus_return_en = r.evsel[`PMST_EV_BUS_RET];
  assign spare_board_output = r.evsel[`PMST_EV_SPARE];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  thr_req_set_a: assert property (ev_wake && throttle_state |=> r.wake[`PMST_WK_THR_REQ])
    else $error("throttle wake request not set");
  thr_smi_a: assert property (r.wake[3] && r.wake[2] |-> smi)
    else $error("throttle wake did not raise smi");
  sys_smi_a: assert property (r.wake[0] && r.wake[1] |-> smi)
    else $error("system wake did not raise smi");
  sys_req_set_a: assert property (ev_wake && system_standby |=> r.wake[0])
    else $error("system wake request not set");
  cnt_read_a: assert property (arvalid && arready && araddr[8:2] == `PMST_IDX_MON_LO
      |=> rvalid && rdata[7:0] == $past(mon_if.count[7:0]))
    else $error("count read is not the running count");
  bus_ret_a: assert property ($changed(bus_return_en) |-> $past(wr_go)
      && $past(r.aw_idx) == `PMST_IDX_EVSEL)
    else $error("bus return bit moved without a write");
  vid_trap_a: assert property (hit_vmem && sys_if.en && $past(sys_if.en)
      |=> sys_if.count == {8'h00, $past(r.sys_prog)})
    else $error("video memory access did not reload");
  sec_trap_a: assert property (hit_sec && sys_if.en && $past(sys_if.en)
      |=> sys_if.count == {8'h00, $past(r.sys_prog)})
    else $error("secondary drive access did not reload");
  sb_entry_a: assert property (sys_if.expire && r.ctl[`PMST_CTL_SB_SMI_EN]
      |=> system_standby && smi)
    else $error("standby not entered on expiry");
  smi_cause_a: assert property (smi |-> (r.wake[3] && r.wake[2]) || (r.wake[0] && r.wake[1])
      || (r.stat[0] && r.ctl[`PMST_CTL_SB_SMI_EN]))
    else $error("smi without a pending enabled request");

endmodule : pmst_top

// File: dv/pmst_host_model.sv
// Host processor seen from the standby timer block: counts SMI entries and
// reports its throttling state. Assumes it shares aclk with the block.
`timescale 1ns/1ps
module pmst_host_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic smi,
  input wire logic throttle_req,
  output logic throttle_state,
  output int smi_count
);
  logic smi_d;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      smi_d <= 1'b0;
      smi_count <= 0;
      throttle_state <= 1'b0;
    end
    else
    begin
      smi_d <= smi;
      // Each new request is one entry into the handler
      if (smi && !smi_d)
        smi_count <= smi_count + 1;
      throttle_state <= throttle_req;
    end
  end
endmodule : pmst_host_model

// File: dv/pmst_top_bench.sv
// Self-checking bench of the standby timer block: AXI4-Lite registers, slots,
// traps, wake requests and SMI. Assumes short slot parameters.
`timescale 1ns/1ps
`include "pmst_params.svh"
module pmst_top_bench;
  import pmst_pkg::*;
  // Slots spaced 12 apart so each measured length is unambiguous
  localparam logic [31:0] MS [4] = '{32'h14, 32'h20, 32'h2C, 32'h38};
  localparam logic [31:0] SS [4] = '{32'h3C, 32'h48, 32'h54, 32'h60};
  localparam logic [6:0] A_WK = `PMST_IDX_WAKE;
  localparam logic [6:0] A_ML = `PMST_IDX_MON_LO;
  localparam logic [6:0] A_EV = `PMST_IDX_EVSEL;
  localparam logic [6:0] A_CT = `PMST_IDX_CTL;
  localparam logic [6:0] A_ST = `PMST_IDX_STAT;
  // Trap corners: event select, I/O flag, address
  localparam logic [40:0] TT [14] = '{{8'h20, 1'b0, 32'hA0000}, {8'h20, 1'b0, 32'hBFFFF},
    {8'h20, 1'b0, 32'hC0000}, {8'h10, 1'b0, 32'hC7FFF}, {8'h10, 1'b0, 32'hC8000},
    {8'h08, 1'b1, 32'h3B0}, {8'h08, 1'b1, 32'h3DF}, {8'h08, 1'b1, 32'h3E0},
    {8'h08, 1'b0, 32'h3C0}, {8'h04, 1'b1, 32'h17F}, {8'h04, 1'b1, 32'h320},
    {8'h04, 1'b1, 32'h3F7}, {8'h04, 1'b1, 32'h3F6}, {8'h00, 1'b0, 32'hA0000}};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid, wvalid, bready, arvalid, rready, cyc_valid, cyc_io, throttle_req;
  logic awready, wready, bvalid, arready, rvalid, throttle_state, smi, system_standby;
  logic monitor_idle_expired, io_port_hit, bus_return_en, spare_board_output;
  logic [8:0] awaddr, araddr;
  logic [31:0] wdata, rdata, cyc_addr, rd_q, ra;
  logic [31:0] lfsr_r = 32'h7D18;
  logic [3:0] wstrb;
  logic [17:0] ev_pins;
  logic [1:0] bresp, rresp, resp_q;
  pmst_cnt_t port_v;
  int miscompares = 0;
  int total_checks = 0;
  int smi_count, t;

  always #25 aclk = ~aclk;

  pmst_top #(.MON_SLOT0_CYC(MS[0]), .MON_SLOT1_CYC(MS[1]), .MON_SLOT2_CYC(MS[2]),
    .MON_SLOT3_CYC(MS[3]), .SYS_SLOT0_CYC(SS[0]), .SYS_SLOT1_CYC(SS[1]),
    .SYS_SLOT2_CYC(SS[2]), .SYS_SLOT3_CYC(SS[3])) u_pmst_top (.aclk(aclk),
    .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .nmi(ev_pins[0]), .init(ev_pins[1]), .hold(ev_pins[2]), .irq(ev_pins[17:3]),
    .throttle_state(throttle_state), .cyc_valid(cyc_valid), .cyc_io(cyc_io),
    .cyc_addr(cyc_addr), .smi(smi), .system_standby(system_standby),
    .monitor_idle_expired(monitor_idle_expired), .io_port_hit(io_port_hit),
    .bus_return_en(bus_return_en), .spare_board_output(spare_board_output));

  pmst_host_model u_pmst_host_model (.aclk(aclk), .aresetn(aresetn), .smi(smi),
    .throttle_req(throttle_req), .throttle_state(throttle_state), .smi_count(smi_count));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, m, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic trap_hit(input logic [7:0] e, input logic io, input logic [31:0] a);
    if (!io)
      return (e[5] && a[31:17] == 15'h0005) || (e[4] && a[31:15] == 17'h00018);
    return (e[3] && (a[15:4] == 12'h03B || a[15:4] == 12'h03C || a[15:4] == 12'h03D))
      || (e[2] && (a[15:4] == 12'h017 || a[15:4] == 12'h032 || a[15:0] == 16'h03F7));
  endfunction : trap_hit

  // Address and data go out together; each is dropped once taken
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    do
    begin
      @(posedge aclk);
      if (awready && awvalid)
        awvalid <= 1'b0;
      if (wready && wvalid)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    resp_q = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [6:0] idx);
    @(posedge aclk);
    arvalid <= 1'b1;
    rready <= 1'b1;
    araddr <= {idx, 2'b00};
    do
    begin
      @(posedge aclk);
      if (arready && arvalid)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rd_q = rdata;
    resp_q = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic pulse(input int k);
    @(posedge aclk);
    ev_pins <= 18'h00001 << k;
    repeat (2) @(posedge aclk);
    ev_pins <= 18'h00000;
    repeat (6) @(posedge aclk);
  endtask : pulse

  task automatic cyc(input logic io, input logic [31:0] a);
    @(posedge aclk);
    cyc_valid <= 1'b1;
    cyc_io <= io;
    cyc_addr <= a;
    @(posedge aclk);
    cyc_valid <= 1'b0;
  endtask : cyc

  task automatic slot_trial(input logic mon, input logic [1:0] c);
    int n;
    logic [31:0] len;
    wr(A_CT, 8'h00);
    wr(A_ST, 8'h07);
    len = mon ? MS[c] : SS[c];
    if (mon)
    begin
      wr(A_ML, 8'h01);
      wr(`PMST_IDX_MON_HI, 8'h00);
      wr(A_CT, {3'b000, c, 3'b001});
    end
    else
    begin
      wr(A_EV, {6'h00, c});
      wr(`PMST_IDX_SYS_CNT, 8'h01);
      wr(A_CT, 8'h06);
    end
    n = 0;
    while ((mon ? monitor_idle_expired : system_standby) !== 1'b1 && n < 200)
    begin
      @(posedge aclk);
      n++;
    end
    check(32'(n + 2 >= len && n <= len + 6), 32'h1, "slot");
    if (!mon)
      check(smi, 1'b1, "standby smi");
  endtask : slot_trial

  // A trap every 32 cycles keeps a 180-cycle count from running out
  task automatic trap_trial(input logic [40:0] tt);
    wr(A_CT, 8'h00);
    wr(A_ST, 8'h07);
    wr(A_EV, tt[40:33]);
    wr(`PMST_IDX_SYS_CNT, 8'h03);
    wr(A_CT, 8'h06);
    repeat (7)
    begin
      repeat (30) @(posedge aclk);
      cyc(tt[32], tt[31:0]);
    end
    check(system_standby, !trap_hit(tt[40:33], tt[32], tt[31:0]), "trap");
  endtask : trap_trial

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, cyc_valid, cyc_io, throttle_req} = 8'h00;
    {awaddr, araddr, wstrb, ev_pins} = 40'h0000000000;
    {wdata, cyc_addr} = 64'h0000000000000000;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_WK);
    check(rd_q, 32'h0, "wake reset");
    check(smi, 1'b0, "smi reset");
    lfsr_r = lfsr_next(lfsr_r);
    port_v = lfsr_r[15:0] | 16'h8000;
    wr(`PMST_IDX_PORT_LO, port_v[7:0]);
    wr(`PMST_IDX_PORT_HI, port_v[15:8]);
    check(resp_q, `PMST_RESP_OKAY, "port resp");
    rd(`PMST_IDX_PORT_LO);
    check(rd_q, port_v[7:0], "port lo");
    rd(`PMST_IDX_PORT_HI);
    check(rd_q, port_v[15:8], "port hi");
    cyc(1'b1, {16'h0000, port_v});
    #1 check(io_port_hit, 1'b1, "port hit");
    cyc(1'b0, {16'h0000, port_v});
    #1 check(io_port_hit, 1'b0, "memory no hit");
    for (int i = 0; i < 4; i++)
    begin
      wr(A_EV, {i[1:0], 6'h00});
      check(bus_return_en, i[1], "bus return");
      check(spare_board_output, i[0], "spare out");
    end
    wr(7'h00, 8'hFF);
    check(resp_q, `PMST_RESP_SLVERR, "unmapped wr");
    rd(7'h7F);
    check({rd_q[7:0], resp_q}, {8'h00, `PMST_RESP_SLVERR}, "unmapped rd");
    wr(A_ML, 8'h05);
    wr(`PMST_IDX_MON_HI, 8'h01);
    wr(A_CT, 8'h19);
    rd(A_ML);
    check(rd_q, 32'h05, "load lo");
    rd(`PMST_IDX_MON_HI);
    check(rd_q, 32'h01, "load hi");
    repeat (168) @(posedge aclk);
    rd(A_ML);
    check(rd_q, 32'h02, "running");
    pulse(1);
    rd(A_ML);
    check(rd_q, 32'h02, "init no reload");
    lfsr_r = lfsr_next(lfsr_r);
    t = lfsr_r % 18;
    pulse(t == 1 ? 0 : t);
    rd(A_ML);
    check(rd_q, 32'h05, "reload");
    for (int c = 0; c < 4; c++)
      slot_trial(1'b1, c[1:0]);
    for (int c = 0; c < 4; c++)
      slot_trial(1'b0, c[1:0]);
    wr(A_ST, 8'h01);
    check(smi, 1'b0, "smi clear");
    wr(A_CT, 8'h00);
    wr(A_WK, 8'h02);
    t = smi_count;
    lfsr_r = lfsr_next(lfsr_r);
    pulse(lfsr_r % 18);
    check(smi, 1'b1, "standby wake");
    check(smi_count - t, 1, "host entry");
    rd(A_WK);
    check(rd_q, 32'h03, "standby req");
    wr(A_WK, 8'h01);
    check(smi, 1'b0, "wake clear");
    wr(A_ST, 8'h07);
    throttle_req <= 1'b1;
    wr(A_WK, 8'h04);
    for (int k = 0; k < 18; k++)
    begin
      pulse(k);
      check(smi, 1'b1, "throttle smi");
      rd(A_WK);
      check(rd_q, 32'h0C, "throttle req");
      wr(A_WK, 8'h0C);
      check(smi, 1'b0, "throttle clear");
    end
    wr(A_WK, 8'h00);
    pulse(2);
    check(smi, 1'b0, "masked");
    rd(A_WK);
    check(rd_q, 32'h08, "req no enable");
    throttle_req <= 1'b0;
    wr(A_WK, 8'h08);
    pulse(0);
    rd(A_WK);
    check(rd_q, 32'h00, "normal state");
    foreach (TT[i])
      trap_trial(TT[i]);
    for (int i = 0; i < 8; i++)
    begin
      lfsr_r = lfsr_next(lfsr_r);
      ra = lfsr_r[8] ? {22'h000000, lfsr_r[18:9]} : 32'hA0000 + {14'h0000, lfsr_r[26:9]};
      trap_trial({lfsr_r[7:0] & 8'h3C, lfsr_r[8], ra});
    end
    results();
  end

  // The planned run is near 6500 cycles
  initial
  begin
    repeat (40000) @(posedge aclk);
    miscompares++;
    results();
  end
endmodule : pmst_top_bench
